//--- cmort_pkg.sv
// Purpose: shared constants and carrier types for the message object retry timing block
// Assumes: 32-bit register port, word addresses, 15 message objects
// Notes:   offsets are word indices on the plain register port
package cmort_pkg;

    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 8;
    localparam int ID_W    = 29;
    localparam int NUM_OBJ = 15;
    localparam int BRP_W   = 6;
    localparam int IDLE_W  = 3;
    localparam int BITC_W  = 16;
    localparam int TQ_BIT  = 8;

    // register word offsets
    localparam logic [ADDR_W-1:0] OFF_BT_ONE    = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_BT_THREE  = 8'h01;
    localparam logic [ADDR_W-1:0] OFF_ENABLE    = 8'h02;
    localparam logic [ADDR_W-1:0] OFF_DIR       = 8'h03;
    localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_MASK      = 8'h05;
    localparam logic [ADDR_W-1:0] OFF_STATE     = 8'h06;
    localparam logic [ADDR_W-1:0] OFF_ID_BASE   = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_IDM_BASE  = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_BANK_MASK = 8'hF0;
    localparam logic [ADDR_W-1:0] OFF_IDX_MASK  = 8'h0F;

    // field positions
    localparam int BRP_LSB     = 0;
    localparam int BRP_MSB     = 5;
    localparam int SMP_BIT     = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_TX_BIT   = 1;
    localparam int ST_LOST_BIT = 2;
    localparam int ST_ACC_BIT  = 3;
    localparam int ST_IDLE_LSB = 4;
    localparam int ST_OBJ_LSB  = 8;

    // reset values
    localparam logic [BRP_W-1:0]   BRP_RST  = 6'h00;
    localparam logic               SMP_RST  = 1'h0;
    localparam logic [NUM_OBJ-1:0] OBJ_RST  = 15'h0000;
    localparam logic [ID_W-1:0]    ID_RST   = 29'h00000000;
    localparam logic [DATA_W-1:0]  WORD_RST = 32'h00000000;

    // intermission lengths in bit times
    localparam logic [IDLE_W-1:0] INTER_BITS      = 3'h3;
    localparam logic [IDLE_W-1:0] INTER_LOST_BITS = 3'h4;
    localparam logic [IDLE_W-1:0] IDLE_MAX        = 3'h7;
    // software re-arm window after posting, in bit times
    localparam int REARM_STD_BITS = 19;
    localparam int REARM_EXT_BITS = 39;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } cmort_reg_req_t;

    typedef struct packed {
        logic            busy;
        logic            dlc_start;
        logic            eof6;
        logic            frame_ok;
        logic            arb_lost;
        logic            tx_done;
        logic [ID_W-1:0] id;
    } cmort_bus_evt_t;

    typedef enum logic [1:0] {
        CMORT_ST_IDLE = 2'b01,
        CMORT_ST_TX   = 2'b10
    } cmort_state_t;

endpackage : cmort_pkg

//--- cmort_core.sv
// Purpose: message object arming, acceptance, retry and intermission timing of a CAN controller
// Assumes: frame decoder supplies bus events synchronous to clk
// Notes:   one bit time is (prescaler+1)*TQ_PER_BIT clocks
// What this block does
// - a transmit armed during a busy bus waits for a 3-bit intermission before starting.
// - after lost arbitration with a local receive object accepting, retry after 3 bits.
// - after lost arbitration with no local acceptor, retry only after 4 idle bits.
// - receive status and complete flag are posted right after the sixth EOF bit.
// - posting at EOF bit six leaves 19 (standard) or 39 (extended) bits to re-arm.
// - the last object only takes frames that no other armed receive object accepted.
// - prescaler is bits 5..0 of timing reg one; three-sample is bit 0 of timing reg three.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module cmort_core #(
    parameter int NUM_OBJ    = cmort_pkg::NUM_OBJ,
    parameter int TQ_PER_BIT = cmort_pkg::TQ_BIT
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // register port
    input  wire cmort_pkg::cmort_reg_req_t     req,
    output logic [cmort_pkg::DATA_W-1:0]       rdata,
    // bus events from the frame decoder
    input  wire cmort_pkg::cmort_bus_evt_t     evt,
    // transmit control
    output logic                               tx_active,
    output logic [NUM_OBJ-1:0]                 tx_obj,
    output logic                               three_sample_mode,
    // interrupt
    output logic                               irq
);
    localparam int LOW = NUM_OBJ - 1;
    localparam int IDX_W = $clog2(NUM_OBJ);

    // register state
    logic [cmort_pkg::BRP_W-1:0]  bit_rate_prescaler,  next_bit_rate_prescaler;
    logic                         next_three_sample_mode;
    logic [NUM_OBJ-1:0]           enable,  next_enable;
    logic [NUM_OBJ-1:0]           dir,     next_dir;
    logic [NUM_OBJ-1:0]           status,  next_status;
    logic [NUM_OBJ-1:0]           mask,    next_mask;
    logic [cmort_pkg::ID_W-1:0]   obj_id   [NUM_OBJ];
    logic [cmort_pkg::ID_W-1:0]   obj_idm  [NUM_OBJ];
    logic [cmort_pkg::DATA_W-1:0] next_rdata;

    // timing and protocol state
    logic [cmort_pkg::BITC_W-1:0] bit_cnt,   next_bit_cnt;
    logic [cmort_pkg::IDLE_W-1:0] idle_bits, next_idle_bits;
    logic                         lost,      next_lost;
    logic                         rx_acc,    next_rx_acc;
    logic [NUM_OBJ-1:0]           rx_win,    next_rx_win;
    logic [NUM_OBJ-1:0]           next_tx_obj;
    cmort_pkg::cmort_state_t      state,     next_state;

    logic [NUM_OBJ-1:0]           hit, hit_other, win_now, pend, pend_first;
    logic [cmort_pkg::BITC_W-1:0] bit_len;
    logic                         bit_tick, tx_go, rx_post, bank_id, bank_idm;
    logic [cmort_pkg::IDLE_W-1:0] need_bits;
    logic [IDX_W-1:0]             idx;

    assign bank_id  = (req.addr & cmort_pkg::OFF_BANK_MASK) == cmort_pkg::OFF_ID_BASE;
    assign bank_idm = (req.addr & cmort_pkg::OFF_BANK_MASK) == cmort_pkg::OFF_IDM_BASE;
    assign idx      = IDX_W'(req.addr & cmort_pkg::OFF_IDX_MASK);

    // per-object acceptance filter
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OBJ; gi++) begin : g_obj
            assign hit[gi] = enable[gi] & dir[gi]
                           & (((evt.id ^ obj_id[gi]) & obj_idm[gi]) == '0);
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    obj_id[gi]  <= cmort_pkg::ID_RST;
                    obj_idm[gi] <= cmort_pkg::ID_RST;
                end else begin
                    if (req.wr && bank_id && idx == IDX_W'(gi)) begin
                        obj_id[gi]  <= req.wdata[cmort_pkg::ID_W-1:0];
                    end
                    if (req.wr && bank_idm && idx == IDX_W'(gi)) begin
                        obj_idm[gi] <= req.wdata[cmort_pkg::ID_W-1:0];
                    end
                end
            end
        end
    endgenerate

    // lowest index wins; the last object only when nobody else hit
    always_comb begin
        hit_other = hit & ~(NUM_OBJ'(1) << LOW);
        if (|hit_other) begin
            win_now = hit_other & (~hit_other + NUM_OBJ'(1));
        end else begin
            win_now = hit;
        end
        pend       = enable & ~dir;
        pend_first = pend & (~pend + NUM_OBJ'(1));
    end

    // bit time base, restarted by bus activity
    assign bit_len  = cmort_pkg::BITC_W'((int'(bit_rate_prescaler) + 1) * TQ_PER_BIT);
    assign bit_tick = !evt.busy && (bit_cnt == bit_len - cmort_pkg::BITC_W'(1));

    always_comb begin
        next_bit_cnt   = bit_cnt;
        next_idle_bits = idle_bits;
        if (evt.busy || bit_tick) begin
            next_bit_cnt = '0;
        end else begin
            next_bit_cnt = bit_cnt + cmort_pkg::BITC_W'(1);
        end
        if (evt.busy) begin
            next_idle_bits = '0;
        end else if (bit_tick && idle_bits != cmort_pkg::IDLE_MAX) begin
            next_idle_bits = idle_bits + cmort_pkg::IDLE_W'(1);
        end
    end

    // intermission needed before the next start of frame
    always_comb begin
        if (lost && !rx_acc) begin
            need_bits = cmort_pkg::INTER_LOST_BITS;
        end else begin
            need_bits = cmort_pkg::INTER_BITS;
        end
    end

    assign tx_go   = state == cmort_pkg::CMORT_ST_IDLE && |pend && !evt.busy
                   && idle_bits >= need_bits;
    assign rx_post = evt.eof6 && evt.frame_ok && !tx_active;

    // transmit and acceptance sequencing
    always_comb begin
        next_state  = state;
        next_tx_obj = tx_obj;
        next_lost   = lost;
        next_rx_acc = rx_acc;
        next_rx_win = rx_win;
        if (evt.dlc_start) begin
            next_rx_win = win_now;
            next_rx_acc = |hit;
        end
        unique case (state)
            cmort_pkg::CMORT_ST_IDLE: begin
                if (tx_go) begin
                    next_state  = cmort_pkg::CMORT_ST_TX;
                    next_tx_obj = pend_first;
                    next_lost   = 1'b0;
                end
            end
            cmort_pkg::CMORT_ST_TX: begin
                if (evt.arb_lost) begin
                    next_state  = cmort_pkg::CMORT_ST_IDLE;
                    next_lost   = 1'b1;
                    next_rx_acc = 1'b0;
                end else if (evt.tx_done) begin
                    next_state  = cmort_pkg::CMORT_ST_IDLE;
                end
            end
        endcase
    end

    // software registers; hardware set beats write-one-to-clear
    always_comb begin
        next_bit_rate_prescaler = bit_rate_prescaler;
        next_three_sample_mode  = three_sample_mode;
        next_enable = enable;
        next_dir    = dir;
        next_mask   = mask;
        next_status = status;
        if (req.wr) begin
            unique case (req.addr)
                cmort_pkg::OFF_BT_ONE: begin
                    next_bit_rate_prescaler =
                        req.wdata[cmort_pkg::BRP_MSB:cmort_pkg::BRP_LSB];
                end
                cmort_pkg::OFF_BT_THREE: begin
                    next_three_sample_mode = req.wdata[cmort_pkg::SMP_BIT];
                end
                cmort_pkg::OFF_ENABLE: next_enable = req.wdata[NUM_OBJ-1:0];
                cmort_pkg::OFF_DIR:    next_dir    = req.wdata[NUM_OBJ-1:0];
                cmort_pkg::OFF_MASK:   next_mask   = req.wdata[NUM_OBJ-1:0];
                cmort_pkg::OFF_STATUS: next_status = status & ~req.wdata[NUM_OBJ-1:0];
                default: ;
            endcase
        end
        if (rx_post) begin
            next_status = next_status | rx_win;
            next_enable = next_enable & ~rx_win;
        end
        if (state == cmort_pkg::CMORT_ST_TX && evt.tx_done && !evt.arb_lost) begin
            next_status = next_status | tx_obj;
            next_enable = next_enable & ~tx_obj;
        end
    end

    // read data, valid the cycle after the read strobe
    always_comb begin
        next_rdata = cmort_pkg::WORD_RST;
        if (req.rd) begin
            if (bank_id && int'(idx) < NUM_OBJ) begin
                next_rdata[cmort_pkg::ID_W-1:0] = obj_id[idx];
            end else if (bank_idm && int'(idx) < NUM_OBJ) begin
                next_rdata[cmort_pkg::ID_W-1:0] = obj_idm[idx];
            end else begin
                unique case (req.addr)
                    cmort_pkg::OFF_BT_ONE: begin
                        next_rdata[cmort_pkg::BRP_MSB:cmort_pkg::BRP_LSB] = bit_rate_prescaler;
                    end
                    cmort_pkg::OFF_BT_THREE: next_rdata[cmort_pkg::SMP_BIT] = three_sample_mode;
                    cmort_pkg::OFF_ENABLE:   next_rdata[NUM_OBJ-1:0] = enable;
                    cmort_pkg::OFF_DIR:      next_rdata[NUM_OBJ-1:0] = dir;
                    cmort_pkg::OFF_STATUS:   next_rdata[NUM_OBJ-1:0] = status;
                    cmort_pkg::OFF_MASK:     next_rdata[NUM_OBJ-1:0] = mask;
                    cmort_pkg::OFF_STATE: begin
                        next_rdata[cmort_pkg::ST_BUSY_BIT] = evt.busy;
                        next_rdata[cmort_pkg::ST_TX_BIT]   = tx_active;
                        next_rdata[cmort_pkg::ST_LOST_BIT] = lost;
                        next_rdata[cmort_pkg::ST_ACC_BIT]  = rx_acc;
                        next_rdata[cmort_pkg::ST_IDLE_LSB +: cmort_pkg::IDLE_W] = idle_bits;
                        next_rdata[cmort_pkg::ST_OBJ_LSB +: NUM_OBJ] = tx_obj;
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_rate_prescaler <= cmort_pkg::BRP_RST;
            three_sample_mode  <= cmort_pkg::SMP_RST;
            enable    <= cmort_pkg::OBJ_RST;
            dir       <= cmort_pkg::OBJ_RST;
            status    <= cmort_pkg::OBJ_RST;
            mask      <= cmort_pkg::OBJ_RST;
            rdata     <= cmort_pkg::WORD_RST;
            bit_cnt   <= '0;
            idle_bits <= '0;
            lost      <= 1'b0;
            rx_acc    <= 1'b0;
            rx_win    <= cmort_pkg::OBJ_RST;
            tx_obj    <= cmort_pkg::OBJ_RST;
            state     <= cmort_pkg::CMORT_ST_IDLE;
        end else begin
            bit_rate_prescaler <= next_bit_rate_prescaler;
            three_sample_mode  <= next_three_sample_mode;
            enable    <= next_enable;
            dir       <= next_dir;
            status    <= next_status;
            mask      <= next_mask;
            rdata     <= next_rdata;
            bit_cnt   <= next_bit_cnt;
            idle_bits <= next_idle_bits;
            lost      <= next_lost;
            rx_acc    <= next_rx_acc;
            rx_win    <= next_rx_win;
            tx_obj    <= next_tx_obj;
            state     <= next_state;
        end
    end

    assign tx_active = state == cmort_pkg::CMORT_ST_TX;
    assign irq       = |(status & mask);

    // checks
    sequence s_bus_free;
        !evt.busy && state == cmort_pkg::CMORT_ST_IDLE && |pend;
    endsequence

    sequence s_lost_accepted;
        lost && rx_acc;
    endsequence

    a_start_after_three: assert property (@(posedge clk) disable iff (rst)
        $rose(tx_active) |-> $past(idle_bits) >= cmort_pkg::INTER_BITS && !$past(evt.busy))
        else $error("transmit started before 3 idle bits");

    a_retry_three_bits: assert property (@(posedge clk) disable iff (rst)
        s_bus_free and s_lost_accepted and (idle_bits == cmort_pkg::INTER_BITS) |=> tx_active)
        else $error("accepted loss did not retry after 3 idle bits");

    a_retry_four_bits: assert property (@(posedge clk) disable iff (rst)
        $rose(tx_active) && $past(lost) && !$past(rx_acc)
        |-> $past(idle_bits) >= cmort_pkg::INTER_LOST_BITS)
        else $error("unaccepted loss retried before 4 idle bits");

    a_arm_by_dlc: assert property (@(posedge clk) disable iff (rst)
        evt.dlc_start |=> rx_win == $past(win_now) && rx_acc == ($past(hit) != '0))
        else $error("acceptance not captured at the DLC start");

    a_post_at_eof: assert property (@(posedge clk) disable iff (rst)
        rx_post && |rx_win |=> (status & $past(rx_win)) == $past(rx_win)
                               && (enable & $past(rx_win)) == '0)
        else $error("receive status not posted after EOF bit six");

    a_last_lowest: assert property (@(posedge clk) disable iff (rst)
        evt.dlc_start && |hit_other |=> !rx_win[LOW] && $onehot(rx_win))
        else $error("last object took a frame another object accepted");

    a_prescaler_field: assert property (@(posedge clk) disable iff (rst)
        req.wr && req.addr == cmort_pkg::OFF_BT_ONE
        |=> bit_rate_prescaler == $past(req.wdata[cmort_pkg::BRP_MSB:cmort_pkg::BRP_LSB]))
        else $error("prescaler field not taken from bits 5..0");

    a_retry_pending: assert property (@(posedge clk) disable iff (rst)
        tx_active && evt.arb_lost |=> !tx_active && (enable & tx_obj) == tx_obj ##1 lost)
        else $error("lost transmit dropped its pending request");

endmodule : cmort_core

//--- cmort_bus_model.sv
// Purpose: far-side model of other CAN nodes, seen as frame decoder events
// Assumes: one bit time is BIT_CLK clocks; standard and extended frame layouts
// Notes:   released id and frame_ok lines show the inverse of their last value
`timescale 1ns/1ps
module cmort_bus_model #(
    parameter int BIT_CLK = 8
) (
    // clock
    input  wire logic                clk,
    // device status
    input  wire logic                tx_active,
    // events toward the device
    output cmort_pkg::cmort_bus_evt_t evt
);
    initial evt = '0;

    // dlc field to end of frame
    task automatic tail(input logic [cmort_pkg::ID_W-1:0] fid, input logic ok);
        @(posedge clk);
        evt.id        <= fid;
        evt.dlc_start <= 1'b1;
        @(posedge clk);
        evt.dlc_start <= 1'b0;
        repeat (28 * BIT_CLK) @(posedge clk);
        evt.frame_ok <= ok;
        evt.eof6     <= 1'b1;
        @(posedge clk);
        evt.eof6     <= 1'b0;
        evt.id       <= ~fid;
        evt.frame_ok <= ~ok;
        repeat (BIT_CLK) @(posedge clk);
        evt.busy <= 1'b0;
    endtask : tail

    // frame of another node after a 3-bit intermission
    task automatic frame(input logic [cmort_pkg::ID_W-1:0] fid, input logic ext);
        repeat (3 * BIT_CLK) @(posedge clk);
        evt.busy <= 1'b1;
        repeat ((ext ? 35 : 15) * BIT_CLK) @(posedge clk);
        tail(fid, 1'b1);
    endtask : frame

    // own transmission: lost to wid, or completed
    task automatic own(input logic lose, input logic [cmort_pkg::ID_W-1:0] wid);
        // look at settled values between edges; the watchdog ends a start that never comes
        @(negedge clk);
        while (tx_active !== 1'b1) begin
            @(negedge clk);
        end
        @(posedge clk);
        evt.busy <= 1'b1;
        repeat (12 * BIT_CLK) @(posedge clk);
        if (lose) begin
            evt.arb_lost <= 1'b1;
            @(posedge clk);
            evt.arb_lost <= 1'b0;
            tail(wid, 1'b1);
        end else begin
            repeat (30 * BIT_CLK) @(posedge clk);
            evt.tx_done <= 1'b1;
            @(posedge clk);
            evt.tx_done <= 1'b0;
            repeat (BIT_CLK) @(posedge clk);
            evt.busy <= 1'b0;
        end
    endtask : own
endmodule : cmort_bus_model

//--- cmort_core_tb_top.sv
// Purpose: self-checking bench for the message object retry timing block
// Assumes: prescaler 0 and TQ_PER_BIT 8, so one bit time is 8 clocks
// Notes:   other nodes come from cmort_bus_model
`timescale 1ns/1ps
module cmort_core_tb_top;
    localparam int          BIT  = 8;
    localparam logic [28:0] ID_A = 29'h0000123;
    localparam logic [28:0] ID_B = 29'h00000AA;
    logic                          clk;
    logic                          rst;
    cmort_pkg::cmort_reg_req_t     req;
    logic [cmort_pkg::DATA_W-1:0]  rdata;
    cmort_pkg::cmort_bus_evt_t     evt;
    logic                          tx_active;
    logic [cmort_pkg::NUM_OBJ-1:0] tx_obj;
    logic                          three_sample_mode;
    logic                          irq;
    int                            mismatches;
    int                            checks;

    cmort_core #(.TQ_PER_BIT(BIT)) DUT (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
        .evt(evt), .tx_active(tx_active), .tx_obj(tx_obj),
        .three_sample_mode(three_sample_mode), .irq(irq));
    cmort_bus_model #(.BIT_CLK(BIT)) bus (.clk(clk), .tx_active(tx_active), .evt(evt));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge clk);
        req.wr    <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge clk);
        req.rd   <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rdc

    // dlc strobe when dlc is set, else the eof6 strobe
    task automatic wait_evt(input logic dlc);
        int n;
        n = 0;
        while ((dlc ? evt.dlc_start : evt.eof6) !== 1'b1 && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(32'(n < 1000), 32'h1);
    endtask : wait_evt

    task automatic post_check();
        wait_evt(1'b0);
        chk(irq, 32'h0);
        @(posedge clk);
        #1;
        chk(irq, 32'h1);
    endtask : post_check

    // clocks from bus release to transmission start
    task automatic gap(input int need);
        int n;
        n = 0;
        while (tx_active !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(32'(n >= need * BIT && n <= need * BIT + 2), 32'h1);
    endtask : gap

    task automatic t_regs();
        chk({tx_active, tx_obj, three_sample_mode, irq}, 32'h0);
        rdc(cmort_pkg::OFF_STATUS, 32'h0);
        rdc(cmort_pkg::OFF_ENABLE, 32'h0);
        wr(cmort_pkg::OFF_BT_ONE, 32'h000000E5);
        rdc(cmort_pkg::OFF_BT_ONE, 32'h00000025);
        wr(cmort_pkg::OFF_BT_THREE, 32'h00000001);
        @(posedge clk);
        #1;
        chk(three_sample_mode, 32'h1);
        rdc(cmort_pkg::OFF_BT_THREE, 32'h1);
        rdc(8'h0F, 32'h0);
        wr(cmort_pkg::OFF_BT_THREE, 32'h0);
        wr(cmort_pkg::OFF_BT_ONE, 32'h0);
        $display("test regs done");
    endtask : t_regs

    task automatic t_busy_tx();
        wr(cmort_pkg::OFF_MASK, 32'h00007FFF);
        wr(cmort_pkg::OFF_DIR, 32'h0);
        rdc(cmort_pkg::OFF_MASK, 32'h00007FFF);
        rdc(cmort_pkg::OFF_DIR, 32'h0);
        fork
            bus.frame(ID_B, 1'b0);
            begin
                repeat (6 * BIT) @(posedge clk);
                wr(cmort_pkg::OFF_ENABLE, 32'h00000004);
                repeat (2) @(posedge clk);
                #1;
                chk(tx_active, 32'h0);
            end
        join
        gap(3);
        chk(32'(tx_obj), 32'h4);
        // tx_obj 4, idle_bits 3, transmitting, bus free, no loss, no acceptor
        rdc(cmort_pkg::OFF_STATE, 32'h00000432);
        bus.own(1'b0, ID_B);
        rdc(cmort_pkg::OFF_STATUS, 32'h4);
        rdc(cmort_pkg::OFF_ENABLE, 32'h0);
        chk(irq, 32'h1);
        wr(cmort_pkg::OFF_MASK, 32'h0);
        @(posedge clk);
        #1;
        chk(irq, 32'h0);
        wr(cmort_pkg::OFF_STATUS, 32'h4);
        wr(cmort_pkg::OFF_MASK, 32'h00007FFF);
        @(posedge clk);
        #1;
        chk(irq, 32'h0);
        $display("test busy tx done");
    endtask : t_busy_tx

    // lost arbitration with or without a local acceptor
    task automatic t_retry(input logic acc);
        wr(cmort_pkg::OFF_ID_BASE + 8'h03, 32'(ID_A));
        wr(cmort_pkg::OFF_IDM_BASE + 8'h03, 32'h1FFFFFFF);
        rdc(cmort_pkg::OFF_ID_BASE + 8'h03, 32'(ID_A));
        rdc(cmort_pkg::OFF_IDM_BASE + 8'h03, 32'h1FFFFFFF);
        wr(cmort_pkg::OFF_DIR, 32'h00000008);
        wr(cmort_pkg::OFF_ENABLE, 32'h0000000C);
        fork
            bus.own(1'b1, acc ? ID_A : ID_B);
            if (acc) post_check();
        join
        gap(acc ? 3 : 4);
        chk(32'(tx_obj), 32'h4);
        bus.own(1'b0, ID_B);
        rdc(cmort_pkg::OFF_STATUS, acc ? 32'hC : 32'h4);
        wr(cmort_pkg::OFF_STATUS, 32'h00007FFF);
        $display("test retry done");
    endtask : t_retry

    task automatic t_prio();
        wr(cmort_pkg::OFF_IDM_BASE + 8'h0E, 32'h0);
        wr(cmort_pkg::OFF_ID_BASE + 8'h05, 32'(ID_B));
        wr(cmort_pkg::OFF_IDM_BASE + 8'h05, 32'h1FFFFFFF);
        wr(cmort_pkg::OFF_DIR, 32'h00004028);
        wr(cmort_pkg::OFF_ENABLE, 32'h00004008);
        fork
            begin
                bus.frame(ID_A, 1'b0);
                bus.frame(ID_A, 1'b1);
            end
            begin
                post_check();
                wr(cmort_pkg::OFF_STATUS, 32'h00000008);
                wr(cmort_pkg::OFF_ENABLE, 32'h00004008);
            end
        join
        rdc(cmort_pkg::OFF_STATUS, 32'h00000008);
        wr(cmort_pkg::OFF_STATUS, 32'h00007FFF);
        fork
            bus.frame(ID_B, 1'b0);
            begin
                wait_evt(1'b1);
                wr(cmort_pkg::OFF_ENABLE, 32'h00004028);
            end
        join
        rdc(cmort_pkg::OFF_STATUS, 32'h00004000);
        $display("test priority done");
    endtask : t_prio

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        mismatches = 0;
        checks = 0;
        rst = 1'b1;
        req = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_busy_tx();
        t_retry(1'b1);
        t_retry(1'b0);
        t_prio();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        complete_run();
    end
endmodule : cmort_core_tb_top
